// file: include/xpb_pkg.sv
// external peripheral bus master: shared constants and carrier types
// assumes a single 100 MHz system clock drives every user of this package
package xpb_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 10;
  // software reset pulse on the reset pin, least time
  localparam int unsigned SW_RST_PULSE_NS = 400;
  localparam int unsigned SW_RST_CYCLES   =
    (SW_RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  SW_RST_CNT_MAX  = 8'(SW_RST_CYCLES - 1);
  // reference clock: input 20 MHz, output twice that
  localparam int unsigned REF_IN_MHZ      = 20;
  localparam int unsigned REF_OUT_MHZ     = 2 * REF_IN_MHZ;
  localparam int unsigned SYS_MHZ         = 1000 / CLK_PERIOD_NS;
  // half period of the reference output in system cycles, rounded down
  localparam int unsigned REF_HALF_CYC    = SYS_MHZ / (2 * REF_OUT_MHZ);
  localparam logic [3:0]  REF_HALF_MAX    = 4'(REF_HALF_CYC - 1);

  // ----------------------------------------------------------------
  // access carriers
  // ----------------------------------------------------------------
  typedef enum logic {XPB_SPACE_MEM, XPB_SPACE_IO} xpb_space_t;

  typedef struct packed {
    logic              read;
    xpb_space_t        space;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } xpb_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data_out;
    logic              data_oe;
    logic              write_strobe_n;
    logic              read_strobe_n;
    logic              valid_strobe_n;
    logic              rd_not_wr;
    logic              wr_not_rd;
    logic              io_device_sel_n;
    logic              memory_sel_n;
  } xpb_pins_t;

  localparam xpb_pins_t PINS_IDLE = '{
    addr: '0, data_out: '0, data_oe: 1'b0,
    write_strobe_n: 1'b1, read_strobe_n: 1'b1, valid_strobe_n: 1'b1,
    rd_not_wr: 1'b1, wr_not_rd: 1'b0,
    io_device_sel_n: 1'b1, memory_sel_n: 1'b1};

endpackage

// file: core/xpb_refclk.sv
// reference clock generator: divides the system clock by two, 50 MHz, where twice the input rate is 40 MHz
// assumes reset comes from the top-level synchroniser
`timescale 1ns/100ps
`default_nettype none
module xpb_refclk
  import xpb_pkg::*;
(
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // chip reset pin level, active low
  input  wire logic pin_rst_n,
  // reference output
  output logic      ref_clock_output
);

  typedef struct packed {
    logic [3:0] cnt;
    logic       level;
  } xpb_ref_st_t;

  xpb_ref_st_t st;
  xpb_ref_st_t next_st;

  always_comb begin
    next_st = st;
    if (!pin_rst_n) begin
      // held low while reset is active [R14]
      next_st = '0;
    end else if (st.cnt == REF_HALF_MAX) begin
      next_st.cnt   = '0;
      next_st.level = ~st.level; // [R13]
    end else begin
      next_st.cnt = st.cnt + 4'h1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign ref_clock_output = st.level;

  a_ref_quiet_rst: assert property (@(posedge mclk) disable iff (!rst_n) // [R14]
    !pin_rst_n |=> !ref_clock_output)
    else $error("reference clock toggled during reset");

  // at 100 MHz the half period rounds down to a single system cycle
  a_ref_half_period: assert property (@(posedge mclk) disable iff (!rst_n) // [R13]
    (pin_rst_n && $rose(ref_clock_output)) ##1 pin_rst_n |-> !ref_clock_output)
    else $error("reference clock high phase too long");

  c_ref_toggles: cover property (@(posedge mclk) disable iff (!rst_n)
    $fell(ref_clock_output));

endmodule
`default_nettype wire

// file: core/xpb_master.sv
// external peripheral bus master: one access at a time, wait states by ready
// assumes ready and data inputs are synchronous to mclk
//
// What this block does
// R1: low reset pin returns everything but the software reset pulse to initial
// R2: software reset briefly drives reset pin low
// R3: write strobe low only while writing
// R4: read strobe low only while reading
// R5: valid strobe low while address, data valid
// R6: direction high on reads, low on writes
// R7: second direction output is always the complement
// R8: ready low inserts one-cycle waits, resampled
// R9: slow target pulls ready low for waits
// R10: startup configuration reads wait for ready
// R11: peripheral select low on peripheral accesses
// R12: memory select low on memory accesses
// R13: reference clock aimed at twice input rate, runs at 50 MHz, half the system clock
// R14: reference clock idle during reset
// R15: sixteen address lines select the target
// R16: sixteen bidirectional data lines carry transfers
// R17: never both selects in one access
// R18: data bus released except while writing
`timescale 1ns/100ps
`default_nettype none
module xpb_master
  import xpb_pkg::*;
(
  // clock and reset
  input  wire logic            mclk,
  input  wire logic            arst_n,
  // reset pin as three signals
  input  wire logic            reset_pin_in_n,
  output logic                 reset_pin_out_n,
  output logic                 reset_pin_oe,
  // software reset request, one-cycle pulse
  input  wire logic            sw_reset,
  // request side
  input  wire logic            req_valid,
  output logic                 req_ready,
  input  wire xpb_req_t        req,
  output logic                 rsp_valid,
  output logic [DATA_W-1:0]    rsp_rdata,
  // startup configuration read pending
  output logic                 cfg_busy,
  // external bus
  output logic [ADDR_W-1:0]    addr,
  input  wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0]    data_out,
  output logic                 data_oe,
  output logic                 write_strobe_n,
  output logic                 read_strobe_n,
  output logic                 valid_strobe_n,
  output logic                 rd_not_wr,
  output logic                 wr_not_rd,
  output logic                 io_device_sel_n,
  output logic                 memory_sel_n,
  input  wire logic            ready,
  output logic                 ref_clock_output
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync;
  logic       rst_n;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {XPB_IDLE, XPB_SETUP, XPB_STROBE, XPB_DONE} xpb_phase_t;

  typedef struct packed {
    xpb_phase_t        phase;
    logic              read;
    xpb_space_t        space;
    logic              cfg_pending;
    logic              cfg_active;
    logic              sw_rst_on;
    logic [7:0]        sw_rst_cnt;
    logic              rsp;
    logic [DATA_W-1:0] rdata;
    xpb_pins_t         pins;
  } xpb_state_t;

  xpb_state_t st;
  xpb_state_t next_st;

  // drive decode shared by setup and strobe phases
  function automatic xpb_pins_t drive_pins(input logic rd, input xpb_space_t sp,
                                           input logic [ADDR_W-1:0] a,
                                           input logic [DATA_W-1:0] d,
                                           input logic strobe);
    xpb_pins_t p;
    p                 = PINS_IDLE;
    p.addr            = a;                       // [R15]
    p.data_out        = d;
    p.data_oe         = !rd;                     // [R16] [R18]
    p.rd_not_wr       = rd;                      // [R6]
    p.wr_not_rd       = !rd;                     // [R7]
    p.memory_sel_n    = (sp != XPB_SPACE_MEM);   // [R12] [R17]
    p.io_device_sel_n = (sp != XPB_SPACE_IO);    // [R11] [R17]
    p.valid_strobe_n  = !strobe;                 // [R5]
    p.read_strobe_n   = !(strobe && rd);         // [R4]
    p.write_strobe_n  = !(strobe && !rd);        // [R3]
    return p;
  endfunction

  always_comb begin
    next_st     = st;
    next_st.rsp = 1'b0;
    // software reset: hold the pin low for its minimum width [R2]
    if (st.sw_rst_on) begin
      if (st.sw_rst_cnt == SW_RST_CNT_MAX) begin
        next_st.sw_rst_on = 1'b0;
      end else begin
        next_st.sw_rst_cnt = st.sw_rst_cnt + 8'h01;
      end
    end else if (sw_reset) begin
      next_st.sw_rst_on  = 1'b1;
      next_st.sw_rst_cnt = 8'h00;
    end
    case (st.phase)
      XPB_IDLE: begin
        next_st.pins = PINS_IDLE;
        // startup configuration read comes first, issued only once ready [R10]
        if (st.cfg_pending && ready) begin
          next_st.phase       = XPB_SETUP;
          next_st.read        = 1'b1;
          next_st.space       = XPB_SPACE_IO;
          next_st.cfg_pending = 1'b0;
          next_st.cfg_active  = 1'b1;
          next_st.pins = drive_pins(1'b1, XPB_SPACE_IO, '0, '0, 1'b0);
        end else if (!st.cfg_pending && req_valid) begin
          next_st.phase = XPB_SETUP;
          next_st.read  = req.read;
          next_st.space = req.space;
          next_st.pins  = drive_pins(req.read, req.space, req.addr, req.wdata, 1'b0);
        end
      end
      XPB_SETUP: begin
        next_st.phase = XPB_STROBE;
        next_st.pins  = drive_pins(st.read, st.space, st.pins.addr, st.pins.data_out, 1'b1);
      end
      XPB_STROBE: begin
        // ready low holds the strobe and retries next cycle [R8] [R9]
        if (ready) begin
          next_st.phase = XPB_DONE;
          next_st.rdata = st.read ? data_in : st.rdata;
          next_st.pins  = drive_pins(st.read, st.space, st.pins.addr,
                                     st.pins.data_out, 1'b0);
          next_st.pins.data_oe = 1'b0;           // [R18]
        end
      end
      XPB_DONE: begin
        next_st.phase      = XPB_IDLE;
        next_st.pins       = PINS_IDLE;
        next_st.rsp        = !st.cfg_active;
        next_st.cfg_active = 1'b0;
      end
      default: begin
        next_st = st;
        next_st.phase = XPB_IDLE;
      end
    endcase
    // reset pin low, from outside or our own pulse, returns all but the pulse flag and count to initial [R1]
    if (!reset_pin_in_n) begin
      next_st = '0;
      next_st.phase       = XPB_IDLE;
      next_st.cfg_pending = 1'b1;
      next_st.pins        = PINS_IDLE;
      next_st.sw_rst_on   = st.sw_rst_on && (st.sw_rst_cnt != SW_RST_CNT_MAX);
      next_st.sw_rst_cnt  = st.sw_rst_on ? st.sw_rst_cnt + 8'h01 : 8'h00;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{phase: XPB_IDLE, read: 1'b0, space: XPB_SPACE_MEM, cfg_pending: 1'b1,
              cfg_active: 1'b0, sw_rst_on: 1'b0, sw_rst_cnt: 8'h00, rsp: 1'b0,
              rdata: '0, pins: PINS_IDLE};
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // open-drain style: only ever pull the pin low
  assign reset_pin_out_n = 1'b0;
  assign reset_pin_oe    = st.sw_rst_on;         // [R2]
  assign req_ready       = (st.phase == XPB_IDLE) && !st.cfg_pending && reset_pin_in_n;
  assign rsp_valid       = st.rsp;
  assign rsp_rdata       = st.rdata;
  assign cfg_busy        = st.cfg_pending || st.cfg_active;
  assign addr            = st.pins.addr;
  assign data_out        = st.pins.data_out;
  assign data_oe         = st.pins.data_oe;
  assign write_strobe_n  = st.pins.write_strobe_n;
  assign read_strobe_n   = st.pins.read_strobe_n;
  assign valid_strobe_n  = st.pins.valid_strobe_n;
  assign rd_not_wr       = st.pins.rd_not_wr;
  assign wr_not_rd       = st.pins.wr_not_rd;
  assign io_device_sel_n = st.pins.io_device_sel_n;
  assign memory_sel_n    = st.pins.memory_sel_n;

  xpb_refclk u_refclk (
    .mclk             (mclk),
    .rst_n            (rst_n),
    .pin_rst_n        (reset_pin_in_n),
    .ref_clock_output (ref_clock_output)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_dir_complement: assert property (@(posedge mclk) disable iff (!rst_n) // [R7]
    wr_not_rd == !rd_not_wr)
    else $error("direction outputs not complementary");

  a_sel_exclusive: assert property (@(posedge mclk) disable iff (!rst_n) // [R17]
    !(!memory_sel_n && !io_device_sel_n))
    else $error("both selects asserted");

  a_wr_strobe_dir: assert property (@(posedge mclk) disable iff (!rst_n) // [R3]
    !write_strobe_n |-> (!rd_not_wr && data_oe && !valid_strobe_n))
    else $error("write strobe outside a write");

  a_rd_strobe_dir: assert property (@(posedge mclk) disable iff (!rst_n) // [R4]
    !read_strobe_n |-> (rd_not_wr && !data_oe && !valid_strobe_n))
    else $error("read strobe outside a read");

  a_bus_released: assert property (@(posedge mclk) disable iff (!rst_n) // [R18]
    data_oe |-> (!rd_not_wr && (st.phase != XPB_IDLE)))
    else $error("data bus driven outside a write");

  a_wait_holds: assert property (@(posedge mclk) disable iff (!rst_n) // [R8]
    (!valid_strobe_n && !ready && reset_pin_in_n) |=> !valid_strobe_n)
    else $error("strobe dropped while ready low");

  a_ready_ends: assert property (@(posedge mclk) disable iff (!rst_n) // [R8]
    (!valid_strobe_n && ready && reset_pin_in_n) |=> valid_strobe_n)
    else $error("strobe held after ready");

  a_cfg_waits: assert property (@(posedge mclk) disable iff (!rst_n) // [R10]
    (st.cfg_pending && !ready) |=> valid_strobe_n)
    else $error("config read issued while ready low");

  a_sel_in_access: assert property (@(posedge mclk) disable iff (!rst_n) // [R11]
    !valid_strobe_n |-> (memory_sel_n != io_device_sel_n))
    else $error("no select during transfer");

  a_swrst_pulse: assert property (@(posedge mclk) disable iff (!rst_n) // [R2]
    $rose(reset_pin_oe) |-> reset_pin_oe [*8])
    else $error("software reset pulse too short");

  a_pin_rst_idle: assert property (@(posedge mclk) disable iff (!rst_n) // [R1]
    !reset_pin_in_n |=> (valid_strobe_n && !data_oe && memory_sel_n && io_device_sel_n))
    else $error("bus active during reset");

  c_write_done: cover property (@(posedge mclk) disable iff (!rst_n)
    !write_strobe_n ##1 write_strobe_n);
  c_read_wait: cover property (@(posedge mclk) disable iff (!rst_n)
    !read_strobe_n && !ready ##1 !read_strobe_n && ready);
  c_cfg_read: cover property (@(posedge mclk) disable iff (!rst_n)
    $fell(cfg_busy));
  c_sw_reset: cover property (@(posedge mclk) disable iff (!rst_n)
    $fell(reset_pin_oe));

endmodule
`default_nettype wire

// file: testbench/xpb_far_model.sv
// far-side model: small word memory with programmable ready waits
// assumes strobes and address come from the bus master on mclk
`timescale 1ns/100ps
`default_nettype none
module xpb_far_model
  import xpb_pkg::*;
(
  // clock
  input  wire logic              mclk,
  // bus from the master
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              write_strobe_n,
  input  wire logic              read_strobe_n,
  // wait control from the bench
  input  wire logic [3:0]        waits,
  input  wire logic              hold,
  // answers
  output logic [DATA_W-1:0]      rdata,
  output logic                   ready
);
  logic [DATA_W-1:0] mem [16];
  logic [DATA_W-1:0] last = '0;
  logic [3:0]        cnt  = '0;
  wire               busy = !(write_strobe_n && read_strobe_n);

  // a slow target pulls ready low for waits cycles of each strobe
  assign ready = !hold && (!busy || cnt >= waits);
  // a released bus shows the inverse of the last word, never a stale match
  assign rdata = (read_strobe_n === 1'b0) ? mem[addr[3:0]] : ~last;

  always @(posedge mclk) begin
    cnt <= busy ? cnt + 4'h1 : 4'h0;
    if (read_strobe_n === 1'b0) last <= mem[addr[3:0]];
    if (write_strobe_n === 1'b0 && ready) mem[addr[3:0]] <= wdata;
  end
endmodule
`default_nettype wire

// file: testbench/testbench.sv
// self-checking bench for the external bus master
// assumes the far-side model answers reads and inserts ready waits
`timescale 1ns/100ps
`default_nettype none
module testbench
  import xpb_pkg::*;
;
  // ------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------
  logic              mclk = 1'b0, arst_n = 1'b0, sw_reset = 1'b0;
  logic              req_valid = 1'b0, hold = 1'b1, ext_low = 1'b0;
  logic [3:0]        waits = '0;
  xpb_req_t          req = '0;
  logic              req_ready, rsp_valid, cfg_busy, rst_out_n, rst_oe;
  logic [DATA_W-1:0] rsp_rdata, data_out, far_rdata;
  logic [ADDR_W-1:0] addr;
  logic              data_oe, write_strobe_n, read_strobe_n, valid_strobe_n;
  logic              rd_not_wr, wr_not_rd, io_device_sel_n, memory_sel_n;
  logic              ready, ref_clock_output;
  int                miscompares = 0, n_compared = 0;
  // open-drain reset pin: low if the device or the outside pulls it
  wire logic pin_n = !((rst_oe && !rst_out_n) || ext_low);
  wire logic [DATA_W-1:0] data_in = data_oe ? data_out : far_rdata;

  always #(CLK_PERIOD_NS / 2) mclk = ~mclk;

  xpb_master u_dut (
    .mclk(mclk), .arst_n(arst_n), .reset_pin_in_n(pin_n),
    .reset_pin_out_n(rst_out_n), .reset_pin_oe(rst_oe), .sw_reset(sw_reset),
    .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .cfg_busy(cfg_busy),
    .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
    .valid_strobe_n(valid_strobe_n), .rd_not_wr(rd_not_wr),
    .wr_not_rd(wr_not_rd), .io_device_sel_n(io_device_sel_n),
    .memory_sel_n(memory_sel_n), .ready(ready),
    .ref_clock_output(ref_clock_output));

  xpb_far_model u_far (
    .mclk(mclk), .addr(addr), .wdata(data_out),
    .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
    .waits(waits), .hold(hold), .rdata(far_rdata), .ready(ready));

  // ------------------------------------------------
  // compare and control helpers
  // ------------------------------------------------
  task automatic chk_bit(input string what, input logic exp, got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_word(input string what, input logic [15:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic complete_run;
    if (miscompares == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // bounded wait; values are read at the edge, before it updates anything
  task automatic wait_for(ref logic sig, input logic lvl, input string what);
    for (int i = 0; i < 200; i++) begin
      @(posedge mclk);
      if (sig === lvl) return;
    end
    chk_bit(what, lvl, sig);
    complete_run();
  endtask

  task automatic chk_idle;
    chk_bit("write_strobe_n", 1'b1, write_strobe_n);
    chk_bit("read_strobe_n", 1'b1, read_strobe_n);
    chk_bit("valid_strobe_n", 1'b1, valid_strobe_n);
    chk_bit("data_oe", 1'b0, data_oe);
    chk_bit("io_device_sel_n", 1'b1, io_device_sel_n);
    chk_bit("memory_sel_n", 1'b1, memory_sel_n);
    chk_bit("wr_not_rd", ~rd_not_wr, wr_not_rd);
  endtask

  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  task automatic startup_hold;
    repeat (5) @(posedge mclk);
    #1;
    chk_idle();
    chk_bit("ref_clock_output", 1'b0, ref_clock_output);
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (20) begin
      @(posedge mclk);
      #1;
      chk_bit("read_strobe_n", 1'b1, read_strobe_n);
      chk_bit("req_ready", 1'b0, req_ready);
    end
    @(posedge mclk);
    hold <= 1'b0;
    wait_for(cfg_busy, 1'b0, "cfg_busy");
    wait_for(req_ready, 1'b1, "req_ready");
  endtask

  task automatic access(input logic rd, input xpb_space_t sp,
                        input logic [15:0] a, d, input logic [3:0] w);
    int k;
    int low;
    low = 0;
    @(posedge mclk);
    waits <= w;
    req <= '{rd, sp, a, d};
    req_valid <= 1'b1;
    wait_for(req_ready, 1'b1, "req_ready");
    req_valid <= 1'b0;
    for (k = 1; k <= 30; k++) begin
      @(posedge mclk);
      #1;
      if (k == 1) begin
        chk_bit("rd_not_wr", rd, rd_not_wr);
        chk_bit("wr_not_rd", !rd, wr_not_rd);
        chk_bit("memory_sel_n", sp == XPB_SPACE_IO, memory_sel_n);
        chk_bit("io_device_sel_n", sp == XPB_SPACE_MEM, io_device_sel_n);
      end
      if (valid_strobe_n === 1'b0) begin
        low++;
        chk_word("addr", a, addr);
        chk_bit("data_oe", !rd, data_oe);
        chk_bit("write_strobe_n", rd, write_strobe_n);
        chk_bit("read_strobe_n", !rd, read_strobe_n);
        if (!rd) chk_word("data_out", d, data_out);
      end
      if (rsp_valid === 1'b1) break;
    end
    if (k > 30) begin
      chk_bit("rsp_valid", 1'b1, rsp_valid);
      complete_run();
    end
    chk_word("strobe cycles", 16'(w) + 16'h1, 16'(low));
    chk_word("answer cycle", 16'(w) + 16'h3, 16'(k));
    chk_idle();
  endtask

  task automatic transfers;
    access(1'b0, XPB_SPACE_MEM, 16'h0005, 16'ha5c3, 4'h0);
    access(1'b1, XPB_SPACE_MEM, 16'h0005, 16'h0000, 4'h2);
    chk_word("rsp_rdata", 16'ha5c3, rsp_rdata);
    access(1'b0, XPB_SPACE_IO, 16'hfff3, 16'h5a3c, 4'h1);
    access(1'b1, XPB_SPACE_IO, 16'hfff3, 16'h0000, 4'h0);
    chk_word("rsp_rdata", 16'h5a3c, rsp_rdata);
  endtask

  task automatic ref_rate;
    int  n;
    logic prev;
    n = 0;
    @(posedge mclk);
    prev = ref_clock_output;
    repeat (8 * REF_HALF_CYC) begin
      @(posedge mclk);
      if (ref_clock_output !== prev) n++;
      prev = ref_clock_output;
    end
    chk_word("ref toggles", 16'h0008, 16'(n));
  endtask

  // outside pull on the reset pin in the middle of a slow read
  task automatic pin_reset_mid;
    @(posedge mclk);
    waits <= 4'h6;
    req <= '{1'b1, XPB_SPACE_MEM, 16'h0005, 16'h0000};
    req_valid <= 1'b1;
    wait_for(req_ready, 1'b1, "req_ready");
    req_valid <= 1'b0;
    wait_for(read_strobe_n, 1'b0, "read_strobe_n");
    ext_low <= 1'b1;
    repeat (2) @(posedge mclk);
    repeat (3) begin
      #1;
      chk_idle();
      chk_bit("req_ready", 1'b0, req_ready);
      chk_bit("ref_clock_output", 1'b0, ref_clock_output);
      @(posedge mclk);
    end
    ext_low <= 1'b0;
    wait_for(req_ready, 1'b1, "req_ready");
  endtask

  task automatic sw_reset_pulse;
    int n;
    @(posedge mclk);
    sw_reset <= 1'b1;
    @(posedge mclk);
    sw_reset <= 1'b0;
    wait_for(rst_oe, 1'b1, "reset_pin_oe");
    n = 1;
    while (n < 200) begin
      @(posedge mclk);
      if (rst_oe !== 1'b1) break;
      n++;
      if (n == 10) chk_bit("req_ready", 1'b0, req_ready);
    end
    chk_word("pin pulse cycles", 16'(SW_RST_CYCLES), 16'(n));
    chk_bit("reset_pin_out_n", 1'b0, rst_out_n);
    wait_for(req_ready, 1'b1, "req_ready");
  endtask

  initial begin
    startup_hold();
    transfers();
    ref_rate();
    pin_reset_mid();
    sw_reset_pulse();
    transfers();
    complete_run();
  end
endmodule
`default_nettype wire
